// ===== core/afedc_pkg.sv
// package for the video digitiser digital control block
// assumes one system clock; serial, strobe and drive-enable pins are sampled through two flip-flops, conv_* inputs are not
package afedc_pkg;
  localparam logic [5:0] ADDR_SETUP1  = 6'h01;
  localparam logic [5:0] ADDR_SETUP2  = 6'h02;
  localparam logic [5:0] ADDR_SETUP3  = 6'h03;
  localparam logic [5:0] ADDR_SRESET  = 6'h04;
  localparam logic [5:0] ADDR_RESTART = 6'h05;
  localparam logic [5:0] ADDR_SETUP4  = 6'h06;
  localparam logic [5:0] ADDR_SETUP5  = 6'h07;
  localparam logic [5:0] ADDR_SETUP6  = 6'h08;
  localparam logic [7:0] DEF_SETUP1   = 8'h03;
  localparam logic [7:0] DEF_SETUP2   = 8'h20;
  localparam logic [7:0] DEF_SETUP3   = 8'h1f;
  localparam logic [7:0] DEF_SETUP4   = 8'h00;
  localparam logic [7:0] DEF_SETUP5   = 8'h00;
  localparam logic [7:0] DEF_SETUP6   = 8'h20;
  localparam int         ADDR_READ_BIT = 4;
  localparam logic [3:0] FRAME_BITS    = 4'he;
  // setup 1 fields
  localparam int S1_EN = 0, S1_DBL_SAMPLE = 1, S1_SINGLE = 2, S1_TWO = 3;
  localparam int S1_RANGE_LO = 4, S1_COMPAT = 7;
  // setup 2 fields
  localparam int S2_FORM_LO = 0, S2_INV = 2, S2_PINS_OFF = 3;
  // setup 4 fields
  localparam int S4_LINE = 0, S4_AUTO = 1, S4_BANK_LO = 2;
  // setup 5 power-down bits
  localparam int S5_RED = 0, S5_GRN = 1, S5_BLU = 2;
  // setup 6 fields
  localparam int S6_DET = 0, S6_DEL_LO = 1, S6_RISE = 4, S6_CLAMP = 6;
  localparam logic [15:0] FULL_CODE = 16'hffff;
  localparam logic [15:0] MID_CODE  = 16'h7fff;
  localparam logic [1:0] BANK_RED = 2'h0, BANK_GRN = 2'h1, BANK_BLU = 2'h2;

  typedef struct packed {
    logic [7:0] setup1;
    logic [7:0] setup2;
    logic [7:0] setup3;
    logic [7:0] setup4;
    logic [7:0] setup5;
    logic [7:0] setup6;
  } afedc_regs_s;

  typedef struct packed {
    logic       chip_enable;
    logic       red_amp_on;
    logic       green_amp_on;
    logic       blue_amp_on;
    logic [1:0] coeff_bank;
    logic       clamp_on;
  } afedc_ctrl_s;

  typedef enum logic [1:0] {
    OUT_IDLE, OUT_BYTE, OUT_NIBBLE
  } afedc_out_e;
endpackage

// ===== core/afedc_top.sv
// digital control and output block of a three-channel video digitiser
// assumes serial pins, strobes and clocks come from outside sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module afedc_top
  import afedc_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            serial_clk_pin,
  input  wire logic            serial_data_in_pin,
  input  wire logic            serial_load_strobe,
  input  wire logic            reset_sample_strobe,
  input  wire logic            video_sample_strobe,
  input  wire logic            output_drive_enable_n,
  input  wire logic            conv_valid,
  input  wire logic [15:0]     conv_code,
  input  wire logic            conv_is_negative,
  output logic [7:0]           pixel_out_bus,
  output logic [7:0]           pixel_out_oe_n,
  output logic                 pixel_out_strobe,
  output logic                 derived_sample_pulse,
  output logic                 sample_now,
  output afedc_pkg::afedc_ctrl_s ctrl,
  output logic [1:0]           black_level_range_sel
);
  import afedc_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // prev_reg holds the last synchronised level for edge detection
  logic [5:0] sync1_reg, sync2_reg, prev_reg;
  wire  [5:0] pins_raw = {output_drive_enable_n, video_sample_strobe,
                          reset_sample_strobe, serial_load_strobe,
                          serial_data_in_pin, serial_clk_pin};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      prev_reg  <= 6'h00;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end
  wire [5:0] rise = sync2_reg & ~prev_reg;
  wire [5:0] fall = ~sync2_reg & prev_reg;
  wire sck_rise     = rise[0];
  wire sck_fall     = fall[0];
  wire din_s        = sync2_reg[1];
  wire load_rise    = rise[2];
  wire rstrobe_rise = rise[3];
  wire vstrobe_rise = rise[4];
  wire vstrobe_fall = fall[4];
  // drive enable pin passes the synchroniser like the others
  wire drive_en_n_s = sync2_reg[5];

  // ----------------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------------
  logic [13:0] shift_reg;
  logic [3:0]  count_reg;
  logic        hold_rd_reg;
  // count saturates at fourteen; extra bits push the oldest out
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= 14'h0000;
      count_reg <= 4'h0;
    end else if (load_rise) begin
      count_reg <= 4'h0;
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[12:0], din_s};
      if (count_reg != FRAME_BITS)
        count_reg <= count_reg + 4'h1;
    end
  end
  wire        frame_full = (count_reg == FRAME_BITS);
  wire [5:0]  fr_addr    = shift_reg[13:8];
  wire [7:0]  fr_data    = shift_reg[7:0];
  wire        load_ok    = load_rise && frame_full;
  wire        is_read    = fr_addr[ADDR_READ_BIT];
  wire        wr_go      = load_ok && !is_read;
  wire        rd_go      = load_ok && is_read;
  wire        soft_rst   = wr_go && (fr_addr == ADDR_SRESET);
  wire        restart    = wr_go && (fr_addr == ADDR_RESTART);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  // short frames never get here: load_ok needs fourteen bits
  afedc_regs_s regs_reg;
  localparam afedc_regs_s REG_DEFAULTS = '{DEF_SETUP1, DEF_SETUP2,
    DEF_SETUP3, DEF_SETUP4, DEF_SETUP5, DEF_SETUP6};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regs_reg <= REG_DEFAULTS;
    end else if (soft_rst) begin
      regs_reg <= REG_DEFAULTS;
    end else if (wr_go) begin
      case (fr_addr)
        ADDR_SETUP1: regs_reg.setup1 <= fr_data;
        ADDR_SETUP2: regs_reg.setup2 <= fr_data;
        ADDR_SETUP3: regs_reg.setup3 <= fr_data;
        ADDR_SETUP4: regs_reg.setup4 <= {4'h0, fr_data[3:0]};
        ADDR_SETUP5: regs_reg.setup5 <= {1'b0, fr_data[6:0]};
        ADDR_SETUP6: regs_reg.setup6 <= {1'b0, fr_data[6:0]};
        default:     regs_reg <= regs_reg;
      endcase
    end
  end

  function automatic logic [7:0] reg_read(input afedc_regs_s r,
                                          input logic [5:0] a);
    logic [5:0] wa;
    wa = a & ~(6'h01 << ADDR_READ_BIT);
    case (wa)
      ADDR_SETUP1: reg_read = r.setup1;
      ADDR_SETUP2: reg_read = r.setup2;
      ADDR_SETUP3: reg_read = r.setup3;
      ADDR_SETUP4: reg_read = r.setup4;
      ADDR_SETUP5: reg_read = r.setup5;
      ADDR_SETUP6: reg_read = r.setup6;
      default:     reg_read = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // read-back shifter, independent of the input shifter
  // ----------------------------------------------------------------------
  logic [7:0] rd_shift_reg;
  logic [3:0] rd_left_reg;
  logic       dout_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_shift_reg <= 8'h00;
      rd_left_reg  <= 4'h0;
      dout_reg     <= 1'b0;
    end else if (rd_go) begin
      rd_shift_reg <= reg_read(regs_reg, fr_addr);
      rd_left_reg  <= 4'h8;
    end else if (sck_fall && rd_left_reg != 4'h0) begin
      dout_reg     <= rd_shift_reg[7];
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
      rd_left_reg  <= rd_left_reg - 4'h1;
    end
  end
  wire reading = (rd_left_reg != 4'h0) || hold_rd_reg;
  // line 7 stays with read data until the next frame is loaded
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      hold_rd_reg <= 1'b0;
    else if (rd_go)
      hold_rd_reg <= 1'b1;
    else if (load_rise)
      hold_rd_reg <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------------
  wire       f_en      = regs_reg.setup1[S1_EN];
  wire       f_compat  = regs_reg.setup1[S1_COMPAT];
  wire [1:0] f_range   = regs_reg.setup1[S1_RANGE_LO +: 2];
  wire       f_single  = regs_reg.setup1[S1_SINGLE];
  wire       f_two     = regs_reg.setup1[S1_TWO];
  wire [1:0] f_form    = regs_reg.setup2[S2_FORM_LO +: 2];
  wire       f_inv     = regs_reg.setup2[S2_INV];
  wire       f_off     = regs_reg.setup2[S2_PINS_OFF];
  wire       f_line    = regs_reg.setup4[S4_LINE];
  wire       f_auto    = regs_reg.setup4[S4_AUTO];
  wire [1:0] f_bank    = regs_reg.setup4[S4_BANK_LO +: 2];
  wire       f_det     = regs_reg.setup6[S6_DET];
  wire [2:0] f_del     = regs_reg.setup6[S6_DEL_LO +: 3];
  wire       f_rise    = regs_reg.setup6[S6_RISE];
  wire       f_clamp   = regs_reg.setup6[S6_CLAMP];

  // ----------------------------------------------------------------------
  // coefficient bank sequencing
  // ----------------------------------------------------------------------
  // restart wins over a strobe pulse in the same cycle
  logic [1:0] cycle_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      cycle_reg <= BANK_RED;
    else if (restart || soft_rst)
      cycle_reg <= BANK_RED;
    else if (f_auto && rstrobe_rise)
      cycle_reg <= (cycle_reg == BANK_BLU) ? BANK_RED
                                           : cycle_reg + 2'h1;
  end
  wire [1:0] bank_next = f_auto ? cycle_reg : f_bank;
  wire clamp_next = f_auto ? f_clamp : sync2_reg[3];

  // ----------------------------------------------------------------------
  // sample strobe detect and delay
  // ----------------------------------------------------------------------
  logic [7:0] dly_reg;
  // tap n of the delay line is the detected edge n + 1 clocks late
  wire edge_hit = f_rise ? vstrobe_rise : vstrobe_fall;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      dly_reg <= 8'h00;
    else
      dly_reg <= {dly_reg[6:0], f_det && edge_hit};
  end
  wire pulse_now = (f_del == 3'h0) ? (f_det && edge_hit)
                                   : dly_reg[f_del - 3'h1];
  wire pin_sample = vstrobe_fall;

  // ----------------------------------------------------------------------
  // output code and formatting
  // ----------------------------------------------------------------------
  logic [15:0] code_reg;
  logic [1:0]  phase_reg;
  afedc_out_e  mode_reg;
  logic [7:0]  word_reg;
  wire [15:0]  offset = (f_range == 2'h3) ? 16'h0000 :
                        (f_range == 2'h2) ? FULL_CODE : MID_CODE;
  wire [15:0]  d1 = conv_is_negative ? offset - conv_code
                                     : offset + conv_code;
  wire [15:0]  d2 = f_inv ? FULL_CODE - d1 : d1;
  wire nibble = (f_form == 2'h3) && f_compat;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      code_reg         <= 16'h0000;
      phase_reg        <= 2'h0;
      mode_reg         <= OUT_IDLE;
      word_reg         <= 8'h00;
      pixel_out_strobe <= 1'b0;
    end else begin
      pixel_out_strobe <= 1'b0;
      case (mode_reg)
        OUT_IDLE: begin
          if (conv_valid && f_en) begin
            code_reg         <= d2;
            word_reg         <= nibble ? {d2[15:12], 4'h0} : d2[15:8];
            pixel_out_strobe <= 1'b1;
            phase_reg        <= 2'h1;
            if (nibble)
              mode_reg <= OUT_NIBBLE;
            else if (f_form != 2'h1)
              mode_reg <= OUT_BYTE;
          end
        end
        OUT_BYTE: begin
          word_reg         <= code_reg[7:0];
          pixel_out_strobe <= 1'b1;
          mode_reg         <= OUT_IDLE;
        end
        OUT_NIBBLE: begin
          word_reg         <= {code_reg[4'hc - {phase_reg, 2'h0} +: 4], 4'h0};
          pixel_out_strobe <= 1'b1;
          phase_reg        <= phase_reg + 2'h1;
          if (phase_reg == 2'h3)
            mode_reg <= OUT_IDLE;
        end
        default: mode_reg <= OUT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pin drive and control outputs
  // ----------------------------------------------------------------------
  logic       sample_reg, derived_reg;
  afedc_ctrl_s ctrl_reg;
  // pin path samples a clock after the fall, detect path after the pulse
  wire sample_next = f_det ? derived_reg : pin_sample;
  wire bus_off = f_off || drive_en_n_s || !f_en;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_reg  <= 1'b0;
      derived_reg <= 1'b0;
      ctrl_reg    <= '0;
    end else begin
      sample_reg  <= sample_next;
      derived_reg <= f_det && pulse_now;
      ctrl_reg.chip_enable  <= f_en;
      ctrl_reg.red_amp_on   <= f_en && !regs_reg.setup5[S5_RED];
      ctrl_reg.green_amp_on <= f_en && !f_line && !f_single &&
                               !regs_reg.setup5[S5_GRN];
      ctrl_reg.blue_amp_on  <= f_en && !f_line && !f_single && !f_two &&
                               !regs_reg.setup5[S5_BLU];
      ctrl_reg.coeff_bank   <= f_line ? bank_next : BANK_RED;
      ctrl_reg.clamp_on     <= clamp_next;
    end
  end
  // read data on line 7 takes priority while a read-back is in flight
  assign pixel_out_bus  = {(reading ? dout_reg : word_reg[7]),
                           word_reg[6:0]};
  assign pixel_out_oe_n = {(drive_en_n_s || (bus_off && !reading)),
                           {7{bus_off || reading}}};
  assign sample_now            = sample_reg;
  assign derived_sample_pulse  = derived_reg;
  assign ctrl                  = ctrl_reg;
  assign black_level_range_sel = f_range;
endmodule
`default_nettype wire

// ===== tb/afedc_top_asserts.sv
// checker on the ports of the digitiser control block
// assumes binding into afedc_top, single sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module afedc_top_asserts
  import afedc_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   output_drive_enable_n,
  input wire logic                   conv_valid,
  input wire logic [7:0]             pixel_out_oe_n,
  input wire logic                   pixel_out_strobe,
  input wire logic                   derived_sample_pulse,
  input wire logic                   sample_now,
  input wire afedc_pkg::afedc_ctrl_s ctrl
);
  //--------------------------------------------
  // port relations
  //--------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_oe_off;
    output_drive_enable_n |-> ##2 pixel_out_oe_n == 8'hff;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe not off");
  property p_first;
    conv_valid && ctrl.chip_enable |=> pixel_out_strobe;
  endproperty
  a_first: assert property (p_first) else $error("no first word");
  property p_blocked;
    conv_valid && !ctrl.chip_enable |=> (!pixel_out_strobe) [*2];
  endproperty
  a_blocked: assert property (p_blocked) else $error("word when off");
  property p_burst;
    pixel_out_strobe [*4] |=> !pixel_out_strobe;
  endproperty
  a_burst: assert property (p_burst) else $error("burst too long");
  property p_single;
    derived_sample_pulse |=> !derived_sample_pulse;
  endproperty
  a_single: assert property (p_single) else $error("pulse too wide");
  property p_sample;
    derived_sample_pulse |=> sample_now;
  endproperty
  a_sample: assert property (p_sample) else $error("no sample");
  property p_bank;
    ctrl.coeff_bank != 2'h3;
  endproperty
  a_bank: assert property (p_bank) else $error("bad bank");
  property p_off;
    !ctrl.chip_enable |-> !(ctrl.red_amp_on | ctrl.green_amp_on);
  endproperty
  a_off: assert property (p_off) else $error("amp on when off");
endmodule
bind afedc_top afedc_top_asserts i_chk (.sys_clk, .rst,
  .output_drive_enable_n, .conv_valid, .pixel_out_oe_n, .pixel_out_strobe,
  .derived_sample_pulse, .sample_now, .ctrl);
`default_nettype wire

// ===== tb/afedc_scanner_model.sv
// scanner controller model for the serial control port
// assumes the block samples these pins with its own clock
`timescale 1ns/1ps
`default_nettype none
module afedc_scanner_model (
  output logic serial_clk_pin,
  output logic serial_data_in_pin,
  output logic serial_load_strobe
);
  initial begin
    serial_clk_pin = 1'b0;
    serial_data_in_pin = 1'b0;
    serial_load_strobe = 1'b0;
  end
  //--------------------------------------------
  // frame: top n bits of w, msb first, then load
  //--------------------------------------------
  task automatic frame(input logic [13:0] w, input int n);
    for (int i = 13; i > 13 - n; i--) begin
      serial_data_in_pin = w[i];
      #62.5 serial_clk_pin = 1'b1;
      #62.5 serial_clk_pin = 1'b0;
    end
    // line released: show the inverse, not the last bit
    serial_data_in_pin = ~serial_data_in_pin;
    #62.5 serial_load_strobe = 1'b1;
    #125 serial_load_strobe = 1'b0;
    #125;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_afedc_top.sv
// self-checking bench for the digitiser control block
// assumes the scanner model drives the serial control pins
`timescale 1ns/1ps
`default_nettype none
module test_afedc_top;
  import afedc_pkg::*;
  logic        sys_clk, serial_clk_pin, serial_data_in_pin;
  logic        serial_load_strobe, rst = 1'b1, conv_valid = 1'b0;
  logic        conv_is_negative = 1'b0, reset_sample_strobe = 1'b0;
  logic        video_sample_strobe = 1'b0, output_drive_enable_n = 1'b0;
  logic [15:0] conv_code = 16'h0, w, x, rd_cap;
  logic [7:0]  pixel_out_bus, pixel_out_oe_n;
  logic        pixel_out_strobe, derived_sample_pulse, sample_now;
  logic [1:0]  black_level_range_sel;
  afedc_ctrl_s ctrl;
  int          bad_count = 0, num_checks = 0, n0, n7, n2;
  afedc_top i_dut (.sys_clk, .rst, .serial_clk_pin, .serial_data_in_pin,
    .serial_load_strobe, .reset_sample_strobe, .video_sample_strobe,
    .output_drive_enable_n, .conv_valid, .conv_code, .conv_is_negative,
    .pixel_out_bus, .pixel_out_oe_n, .pixel_out_strobe,
    .derived_sample_pulse, .sample_now, .ctrl, .black_level_range_sel);
  afedc_scanner_model i_model (.serial_clk_pin, .serial_data_in_pin,
    .serial_load_strobe);
  // controller samples read data on rising serial clock edges
  always @(posedge serial_clk_pin)
    rd_cap <= {rd_cap[14:0], pixel_out_bus[7]};
  //--------------------------------------------
  // tasks
  //--------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_model.frame({a, d}, 14);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic conv(input logic [15:0] c, input int n,
                      output logic [15:0] r);
    r = 16'h0;
    @(posedge sys_clk) conv_valid <= 1'b1;
    conv_code <= c;
    @(posedge sys_clk) conv_valid <= 1'b0;
    for (int k = 0; k < n; k++) begin
      @(negedge sys_clk);
      for (int t = 0; pixel_out_strobe !== 1'b1 && t < 20; t++)
        @(negedge sys_clk);
      r = (n == 4) ? {r[11:0], pixel_out_bus[7:4]} : {r[7:0], pixel_out_bus};
    end
    @(negedge sys_clk);
    chk("extra_word", 16'h0, 16'(pixel_out_strobe));
  endtask
  task automatic edge_lat(input logic rise, input logic [2:0] dl,
                          output int n);
    n = 0;
    wr(ADDR_SETUP6, {3'b001, rise, dl, 1'b1});
    for (int p = 0; p < 3; p++) begin
      @(posedge sys_clk) video_sample_strobe <= rise ^ ~p[0];
      for (int t = 1; t <= 16; t++) begin
        @(negedge sys_clk);
        if (p == 1 && derived_sample_pulse === 1'b1 && n == 0)
          n = t;
        else if (p != 1)
          chk("stray_pulse", 16'h0, 16'(derived_sample_pulse));
        if (p == 1 && n > 0 && t == n + 1)
          chk("sample", 16'h1, 16'(sample_now));
      end
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #300us;
    bad_count++;
    $display("Error watchdog expected end seen hang");
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(ADDR_SRESET, 8'h00);
    chk("ctrl", 16'h3c, 16'(ctrl[6:1]));
    chk("range", 16'(DEF_SETUP1[5:4]), 16'(black_level_range_sel));
    wr(ADDR_SETUP1, 8'h23);
    chk("range", 16'h2, 16'(black_level_range_sel));
    i_model.frame({ADDR_SETUP1, 8'h33}, 10);
    repeat (8) @(posedge sys_clk);
    chk("range", 16'h2, 16'(black_level_range_sel));
    i_model.frame({ADDR_SETUP1 | 6'h10, 8'h00}, 14);
    chk("oe_read", 16'h7f, 16'(pixel_out_oe_n));
    wr(ADDR_SETUP4, 8'h09);
    chk("rd_wr", 16'ha, {black_level_range_sel, ctrl.coeff_bank});
    chk("read_data", 16'h23, 16'(rd_cap[12:5]));
    wr(ADDR_SRESET, 8'h5a);
    chk("sreset", 16'h0, {black_level_range_sel, ctrl.coeff_bank});
    $display("test serial port done");
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_SETUP1, {2'b00, 2'(r), 4'h1});
      conv(16'h0, 2, w);
      chk("zero", r[1] ? (r[0] ? 16'h0 : FULL_CODE) : MID_CODE, w);
    end
    wr(ADDR_SETUP1, 8'hb1);
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_SETUP2, {5'b00100, f[0], 2'(f)});
      conv(16'h4c3a, f == 1 ? 1 : f == 3 ? 4 : 2, w);
      x = f[0] ? FULL_CODE - 16'h4c3a : 16'h4c3a;
      chk("word", f == 1 ? {8'h00, x[15:8]} : x, w);
    end
    @(posedge sys_clk) output_drive_enable_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("oe_off", 16'hff, 16'(pixel_out_oe_n));
    @(posedge sys_clk) output_drive_enable_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("oe_on", 16'h00, 16'(pixel_out_oe_n));
    $display("test output done");
    wr(ADDR_SETUP1, 8'h30);
    chk("enable", 16'h0, 16'(ctrl.chip_enable));
    conv(16'h1234, 0, w);
    wr(ADDR_SETUP1, 8'h01);
    wr(ADDR_SETUP5, 8'h05);
    chk("amps", 16'h2, 16'({ctrl.red_amp_on, ctrl.green_amp_on,
                            ctrl.blue_amp_on}));
    wr(ADDR_SETUP5, 8'h00);
    for (int b = 0; b < 3; b++) begin
      wr(ADDR_SETUP4, {4'h0, 2'(b), 2'b01});
      chk("bank", 16'(b << 2), 16'({ctrl.coeff_bank, ctrl.green_amp_on,
                                     ctrl.blue_amp_on}));
    end
    wr(ADDR_SETUP4, 8'h03);
    for (int k = 1; k < 5; k++) begin
      @(posedge sys_clk) reset_sample_strobe <= 1'b1;
      repeat (4) @(posedge sys_clk);
      reset_sample_strobe <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("cycle", 16'(k % 3), 16'(ctrl.coeff_bank));
    end
    wr(ADDR_RESTART, 8'h00);
    chk("restart", 16'h0, 16'(ctrl.coeff_bank));
    for (int c = 1; c >= 0; c--) begin
      wr(ADDR_SETUP6, {1'b0, 1'(c), 6'h20});
      chk("clamp", 16'(c), 16'(ctrl.clamp_on));
    end
    $display("test coefficients done");
    wr(ADDR_SETUP1, 8'h81);
    edge_lat(1'b0, 3'h0, n0);
    edge_lat(1'b0, 3'h7, n7);
    edge_lat(1'b1, 3'h2, n2);
    chk("found", 16'h1, 16'(n0 > 0));
    chk("delay", 16'h7, 16'(n7 - n0));
    chk("delay_rise", 16'h2, 16'(n2 - n0));
    wr(ADDR_SETUP6, DEF_SETUP6);
    @(posedge sys_clk) video_sample_strobe <= 1'b1;
    @(posedge sys_clk) video_sample_strobe <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pin_sample", 16'h1, 16'(sample_now));
    @(negedge sys_clk);
    chk("pin_sample_end", 16'h0, 16'(sample_now));
    $display("test strobe detect done");
    print_verdict();
  end
endmodule
`default_nettype wire
